/* hw/kpe_pkg.sv */
package kpe_pkg;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_HZ = 125000000;            // System clock rate
  localparam int DEBOUNCE_MS = 200;             // Key contact debounce time
  localparam int DEBOUNCE_CYC = DEBOUNCE_MS * (CLK_HZ / 1000);
  localparam int BLANK_S = 60;                  // Least auto-blank time
  localparam longint BLANK_CYC = longint'(BLANK_S) * longint'(CLK_HZ);
  localparam int TICK_MS_CYC = CLK_HZ / 1000;   // Cycles per millisecond tick

  // ****************************************
  // Key codes
  // ****************************************
  localparam logic [3:0] KEY_CLEAR = 4'hA;      // Blank display, abort sequence
  localparam logic [3:0] KEY_ENTER = 4'hB;      // Commit entered value
  localparam logic [3:0] KEY_PFREQ = 4'hC;      // Present frequency
  localparam logic [3:0] KEY_PPER = 4'hD;       // Present period
  localparam logic [3:0] KEY_SCALED = 4'h8;     // Dual: scaled frequency / 8
  localparam logic [3:0] KEY_MAXF = 4'h9;       // Dual: maximum frequency / 9
  localparam logic [3:0] KEY_ACCEL = 4'h1;      // Dual: accel time / 1
  localparam logic [3:0] KEY_DECEL = 4'h2;      // Dual: decel time / 2
  localparam logic [3:0] KEY_DESF = 4'hE;       // Desired frequency
  localparam logic [3:0] KEY_DESP = 4'hF;       // Desired period
  localparam logic [3:0] KEY_SCALE = 4'h3;      // Dual: scale factor / 3
  localparam logic [3:0] DIGIT_MAX = 4'h9;      // Highest digit code

  // ****************************************
  // Parameter identifiers and digit counts
  // ****************************************
  typedef enum logic [2:0] {
    KPE_P_NONE, KPE_P_MAXF, KPE_P_DESIRED, KPE_P_ACCEL, KPE_P_DECEL, KPE_P_SCALE
  } kpe_param_t;

  localparam logic [2:0] DIGITS_TIME = 3'h2;    // Accel / decel
  localparam logic [2:0] DIGITS_SCALE = 3'h4;   // Scale factor
  localparam logic [2:0] DIGITS_FREQ = 3'h5;    // Frequency / period

  // ****************************************
  // Display messages
  // ****************************************
  typedef enum logic [3:0] {
    KPE_M_BLANK, KPE_M_STOP, KPE_M_RESET, KPE_M_ERROR, KPE_M_PARAM,
    KPE_M_ENTRY, KPE_M_PRESENT, KPE_M_SCALED, KPE_M_USE_DF, KPE_M_USE_DP
  } kpe_msg_t;

  // Display contents carrier
  typedef struct packed {
    kpe_msg_t msg;          // Message shown
    kpe_param_t param;      // Parameter shown or being entered
    logic [19:0] digits;    // Five BCD digits, left first
    logic [4:0] bar_mask;   // Prompting bar per position, left first
    logic period_view;      // Present value shown as period
  } kpe_disp_t;

  // Parameter commit carrier
  typedef struct packed {
    logic valid;            // One-cycle commit strobe
    kpe_param_t param;      // Target parameter
    logic [19:0] value;     // BCD value, left aligned
  } kpe_commit_t;

  localparam logic [19:0] DIGITS_ZERO = 20'h00000; // Empty digit field
endpackage : kpe_pkg

/* hw/kpe_debounce.sv */
// Debounces the 16-key matrix state into one event per press, or one event for the lowest key when presses are accepted together
module kpe_debounce #(
  parameter int DEBOUNCE_CYCLES = kpe_pkg::DEBOUNCE_CYC // Stable cycles per accepted change
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // Raw key contacts, one bit per key
  input wire logic [15:0] key_raw,
  // Key event
  output logic key_evt,
  output logic [3:0] key_code
);

  // ****************************************
  // Synchroniser and filter
  // ****************************************
  logic [15:0] sync1_reg;       // First stage, read only by second
  logic [15:0] sync2_reg;       // Synchronised contacts
  logic [15:0] stable_reg;      // Debounced contact state
  logic [31:0] cnt_reg;         // Stability counter
  logic [15:0] cand_reg;        // Candidate state

  // Two-stage synchroniser
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      sync1_reg <= 16'h0000;
      sync2_reg <= 16'h0000;
    end else begin
      sync1_reg <= key_raw;
      sync2_reg <= sync1_reg;
    end
  end

  // Accept a new contact state only after it stands for the debounce time
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      cand_reg <= 16'h0000;
      cnt_reg <= 32'h0000_0000;
      stable_reg <= 16'h0000;
    end else if (sync2_reg != cand_reg) begin
      cand_reg <= sync2_reg;
      cnt_reg <= 32'h0000_0000;
    end else if (cnt_reg < 32'(DEBOUNCE_CYCLES)) begin
      cnt_reg <= cnt_reg + 32'h0000_0001;
    end else begin
      stable_reg <= cand_reg; // R20
    end
  end

  // Lowest newly pressed key
  function automatic logic [4:0] first_set(input logic [15:0] v);
    first_set = 5'h10;
    for (int i = 15; i >= 0; i--) begin
      if (v[i]) begin
        first_set = 5'(i);
      end
    end
  endfunction

  logic [15:0] prev_reg;        // Debounced state last cycle
  logic [4:0] hit;              // Index of new press, 16 if none

  always_comb begin
    hit = first_set(stable_reg & ~prev_reg);
  end

  // One event per debounced change with new presses, for the lowest key
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      prev_reg <= 16'h0000;
      key_evt <= 1'b0;
      key_code <= 4'h0;
    end else begin
      prev_reg <= stable_reg;
      key_evt <= ~hit[4]; // R20
      key_code <= hit[3:0];
    end
  end

endmodule // kpe_debounce

/* hw/kpe_keypad.sv */
// Operation
// R01: Power-up with run open shows STOP, ready
// R02: Power-up with run closed shows RESET
// R03: RESET holds keypad, output until release; any key also ends the hold here
// R04: Sixteen keys: ten digits plus commands
// R05: Dual key first is command, later digit
// R06: Function key on clear display shows value
// R07: Each parameter needs fixed 2/4/5 digits
// R08: Bars mark positions still needing digits
// R09: Wrong digit count rejects, value kept
// R10: Improper sequence shows diagnostic message
// R11: Idle timeout blanks display like CLEAR; never during digit entry here
// R12: Ramping with no entry shows present value
// R13: CLEAR blanks, ramp display takes precedence
// R14: CLEAR aborts sequence, back to start
// R15: Operator presses CLEAR before dual key
// R16: Mode jumper selects frequency or period
// R17: Present key restores status after blank
// R18: Value committed only on ENTER
// R19: Digit as first key shows ERROR
// R20: Debounce gives one event per press; presses accepted together give one event here
module kpe_keypad #(
  parameter longint BLANK_CYCLES = kpe_pkg::BLANK_CYC,
  parameter int DEBOUNCE_CYCLES = kpe_pkg::DEBOUNCE_CYC
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // Keypad contacts
  input wire logic [15:0] key_raw,
  // External contacts and straps
  input wire logic run_contact,
  input wire logic reference_mode_jumper,
  // Status from the ramp engine
  input wire logic ramping,
  input wire logic [19:0] present_value,
  input wire logic [19:0] param_value,
  // Display and indicators
  output kpe_pkg::kpe_disp_t disp,
  output logic ready_led,
  output logic output_enable,
  output logic freq_mode,
  output kpe_pkg::kpe_param_t view_param,
  // Parameter commit
  output kpe_pkg::kpe_commit_t commit
);

  // ****************************************
  // Input conditioning
  // ****************************************
  logic run_s1_reg;             // First stage, read only by second
  logic run_reg;                // Synchronised run contact
  logic jmp_s1_reg;             // First stage, read only by second
  logic jmp_reg;                // Synchronised jumper
  logic [1:0] settle_reg;       // Fills once the synchronisers hold real levels
  logic key_evt;                // One debounced press
  logic [3:0] key_code;         // Code of that press

  // Two-stage synchronisers for contacts and jumper
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      run_s1_reg <= 1'b0;
      run_reg <= 1'b0;
      jmp_s1_reg <= 1'b1;
      jmp_reg <= 1'b1;
      settle_reg <= 2'h0;
    end else begin
      run_s1_reg <= run_contact;
      run_reg <= run_s1_reg;
      jmp_s1_reg <= reference_mode_jumper;
      jmp_reg <= jmp_s1_reg;
      settle_reg <= {settle_reg[0], 1'b1};
    end
  end

  // Key debounce and event generation
  kpe_debounce #(.DEBOUNCE_CYCLES(DEBOUNCE_CYCLES)) u_debounce (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .key_raw(key_raw), // R04
    .key_evt(key_evt),
    .key_code(key_code)
  );

  // ****************************************
  // Decoding helpers
  // ****************************************
  // Command meaning of a key pressed first
  function automatic kpe_pkg::kpe_param_t cmd_param(input logic [3:0] k);
    case (k)
      kpe_pkg::KEY_MAXF: cmd_param = kpe_pkg::KPE_P_MAXF;
      kpe_pkg::KEY_ACCEL: cmd_param = kpe_pkg::KPE_P_ACCEL;
      kpe_pkg::KEY_DECEL: cmd_param = kpe_pkg::KPE_P_DECEL;
      kpe_pkg::KEY_SCALE: cmd_param = kpe_pkg::KPE_P_SCALE;
      kpe_pkg::KEY_DESF: cmd_param = kpe_pkg::KPE_P_DESIRED;
      kpe_pkg::KEY_DESP: cmd_param = kpe_pkg::KPE_P_DESIRED;
      default: cmd_param = kpe_pkg::KPE_P_NONE;
    endcase
  endfunction

  // Digits required for each parameter
  function automatic logic [2:0] digits_for(input kpe_pkg::kpe_param_t p);
    case (p)
      kpe_pkg::KPE_P_ACCEL: digits_for = kpe_pkg::DIGITS_TIME;
      kpe_pkg::KPE_P_DECEL: digits_for = kpe_pkg::DIGITS_TIME;
      kpe_pkg::KPE_P_SCALE: digits_for = kpe_pkg::DIGITS_SCALE;
      default: digits_for = kpe_pkg::DIGITS_FREQ;
    endcase
  endfunction

  // Bars over positions in [cnt, need)
  function automatic logic [4:0] bars(input logic [2:0] cnt, input logic [2:0] need);
    bars = 5'h00;
    for (int i = 0; i < 5; i++) begin
      if ((3'(i) >= cnt) && (3'(i) < need)) begin
        bars[4 - i] = 1'b1;
      end
    end
  endfunction

  // ****************************************
  // Sequence state
  // ****************************************
  typedef enum logic [2:0] {
    KPE_S_POWERUP, KPE_S_HELD, KPE_S_IDLE, KPE_S_SHOW, KPE_S_ENTRY, KPE_S_ERROR
  } kpe_state_t;

  kpe_state_t state_reg;        // Interpreter state
  kpe_pkg::kpe_param_t param_reg; // Parameter in view or entry
  logic [2:0] cnt_reg;          // Digits keyed so far
  logic [19:0] buf_reg;         // Digits keyed, left aligned
  kpe_pkg::kpe_msg_t msg_reg;   // Message when not in entry
  logic [63:0] idle_reg;        // Cycles since last key
  logic is_digit;               // Key is a digit
  logic is_first;               // No sequence in progress
  logic blank_now;              // Idle timeout reached

  assign is_digit = key_code <= kpe_pkg::DIGIT_MAX;
  assign is_first = (state_reg != KPE_S_ENTRY) &&
                    !((state_reg == KPE_S_SHOW) && (param_reg != kpe_pkg::KPE_P_NONE));
  assign blank_now = idle_reg >= 64'(BLANK_CYCLES);

  // Idle timer for auto-blanking
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      idle_reg <= 64'h0;
    end else if (key_evt) begin
      idle_reg <= 64'h0;
    end else if (!blank_now) begin
      idle_reg <= idle_reg + 64'h1;
    end
  end

  // Key sequence interpreter
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      state_reg <= KPE_S_POWERUP;
      param_reg <= kpe_pkg::KPE_P_NONE;
      cnt_reg <= 3'h0;
      buf_reg <= kpe_pkg::DIGITS_ZERO;
      msg_reg <= kpe_pkg::KPE_M_BLANK;
    end else begin
      case (state_reg)
        // Status at power-up, once contacts are synchronised
        KPE_S_POWERUP: begin
          if (!settle_reg[1]) begin
            state_reg <= KPE_S_POWERUP; // Run contact not yet through both stages
          end else if (run_reg) begin
            state_reg <= KPE_S_HELD;
            msg_reg <= kpe_pkg::KPE_M_RESET; // R02
          end else begin
            state_reg <= KPE_S_SHOW;
            msg_reg <= kpe_pkg::KPE_M_STOP; // R01
          end
        end
        // Held until contact opens or any key
        KPE_S_HELD: begin
          if (!run_reg || key_evt) begin
            state_reg <= KPE_S_SHOW; // R03
            msg_reg <= kpe_pkg::KPE_M_STOP;
          end
        end
        default: begin
          if (key_evt && (key_code == kpe_pkg::KEY_CLEAR)) begin
            state_reg <= KPE_S_IDLE; // R14
            param_reg <= kpe_pkg::KPE_P_NONE;
            cnt_reg <= 3'h0;
            msg_reg <= kpe_pkg::KPE_M_BLANK; // R13
          end else if (key_evt && (key_code == kpe_pkg::KEY_ENTER)) begin
            if ((state_reg == KPE_S_ENTRY) && (cnt_reg == digits_for(param_reg))) begin
              state_reg <= KPE_S_IDLE; // R18
              msg_reg <= kpe_pkg::KPE_M_BLANK;
            end else begin
              state_reg <= KPE_S_ERROR; // R09
              msg_reg <= kpe_pkg::KPE_M_ERROR; // R10
            end
            param_reg <= kpe_pkg::KPE_P_NONE;
            cnt_reg <= 3'h0;
          end else if (key_evt && is_first) begin
            if ((key_code == kpe_pkg::KEY_PFREQ) || (key_code == kpe_pkg::KEY_PPER)) begin
              state_reg <= KPE_S_SHOW; // R17
              param_reg <= kpe_pkg::KPE_P_NONE;
              msg_reg <= run_reg ? kpe_pkg::KPE_M_PRESENT : kpe_pkg::KPE_M_STOP;
            end else if (key_code == kpe_pkg::KEY_SCALED) begin
              state_reg <= KPE_S_SHOW; // R05
              param_reg <= kpe_pkg::KPE_P_NONE;
              msg_reg <= run_reg ? kpe_pkg::KPE_M_SCALED : kpe_pkg::KPE_M_STOP;
            end else if ((key_code == kpe_pkg::KEY_DESP) && jmp_reg) begin
              state_reg <= KPE_S_ERROR; // R16
              msg_reg <= kpe_pkg::KPE_M_USE_DF;
            end else if ((key_code == kpe_pkg::KEY_DESF) && !jmp_reg) begin
              state_reg <= KPE_S_ERROR; // R16
              msg_reg <= kpe_pkg::KPE_M_USE_DP;
            end else if (cmd_param(key_code) != kpe_pkg::KPE_P_NONE) begin
              state_reg <= KPE_S_SHOW; // R06
              param_reg <= cmd_param(key_code); // R05
              msg_reg <= kpe_pkg::KPE_M_PARAM;
            end else begin
              state_reg <= KPE_S_ERROR; // R19
              msg_reg <= kpe_pkg::KPE_M_ERROR;
            end
          end else if (key_evt && is_digit) begin
            // Later keys are digits; too many is an error
            if (cnt_reg >= digits_for(param_reg)) begin
              state_reg <= KPE_S_ERROR; // R09
              param_reg <= kpe_pkg::KPE_P_NONE;
              cnt_reg <= 3'h0;
              msg_reg <= kpe_pkg::KPE_M_ERROR; // R10
            end else begin
              state_reg <= KPE_S_ENTRY; // R07
              cnt_reg <= cnt_reg + 3'h1;
              buf_reg <= (cnt_reg == 3'h0) ? {key_code, 16'h0000} :
                         (buf_reg | ({key_code, 16'h0000} >> (5'(cnt_reg) * 5'h04)));
            end
          end else if (key_evt) begin
            state_reg <= KPE_S_ERROR; // R10
            param_reg <= kpe_pkg::KPE_P_NONE;
            cnt_reg <= 3'h0;
            msg_reg <= kpe_pkg::KPE_M_ERROR;
          end else if (blank_now && (state_reg != KPE_S_ENTRY)) begin
            state_reg <= KPE_S_IDLE; // R11
            param_reg <= kpe_pkg::KPE_P_NONE;
            msg_reg <= kpe_pkg::KPE_M_BLANK;
          end
        end
      endcase
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  // Parameter commit strobe on good ENTER
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      commit <= '0;
    end else begin
      commit.valid <= key_evt && (key_code == kpe_pkg::KEY_ENTER) &&
                      (state_reg == KPE_S_ENTRY) &&
                      (cnt_reg == digits_for(param_reg)); // R18
      commit.param <= param_reg;
      commit.value <= buf_reg;
    end
  end

  // Display image
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      disp <= '0;
    end else begin
      disp.param <= param_reg;
      disp.period_view <= !jmp_reg;
      if (state_reg == KPE_S_ENTRY) begin
        disp.msg <= kpe_pkg::KPE_M_ENTRY;
        disp.digits <= buf_reg;
        disp.bar_mask <= bars(cnt_reg, digits_for(param_reg)); // R08
      end else if (ramping && ((msg_reg == kpe_pkg::KPE_M_BLANK) ||
                               (msg_reg == kpe_pkg::KPE_M_STOP))) begin
        disp.msg <= kpe_pkg::KPE_M_PRESENT; // R12
        disp.digits <= present_value;
        disp.bar_mask <= 5'h00;
      end else begin
        disp.msg <= msg_reg;
        disp.digits <= (msg_reg == kpe_pkg::KPE_M_PARAM) ? param_value : present_value;
        disp.bar_mask <= 5'h00;
      end
    end
  end

  // Indicators and interlock
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      ready_led <= 1'b0;
      output_enable <= 1'b0;
      freq_mode <= 1'b1;
    end else begin
      ready_led <= (state_reg != KPE_S_POWERUP); // R01
      output_enable <= (state_reg != KPE_S_POWERUP) && (state_reg != KPE_S_HELD); // R03
      freq_mode <= jmp_reg; // R16
    end
  end

  assign view_param = param_reg;

endmodule // kpe_keypad

/* verification/kpe_keypad_monitor.sv */
// Watches the keypad front-end ports for status, interlock and display rules
module kpe_keypad_monitor #(
  parameter longint BLANK_CYCLES = kpe_pkg::BLANK_CYC
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // Stimulus side
  input wire logic [15:0] key_raw,
  input wire logic reference_mode_jumper,
  input wire logic ramping,
  input wire logic [19:0] present_value,
  // Design outputs
  input wire kpe_pkg::kpe_disp_t disp,
  input wire logic ready_led,
  input wire logic output_enable,
  input wire logic freq_mode,
  input wire kpe_pkg::kpe_commit_t commit
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_b);

  longint idle_cnt_reg; // Cycles of untouched STOP display

  // ****************************************
  // Idle counter
  // ****************************************
  // Restarts on any key, ramp or other message
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      idle_cnt_reg <= 0;
    end else if (key_raw != 16'h0000 || ramping || disp.msg != kpe_pkg::KPE_M_STOP) begin
      idle_cnt_reg <= 0;
    end else begin
      idle_cnt_reg <= idle_cnt_reg + 1;
    end
  end

  // ****************************************
  // Properties
  // ****************************************
  property p_ready_status;
    $rose(ready_led) |-> disp.msg inside {kpe_pkg::KPE_M_STOP, kpe_pkg::KPE_M_RESET};
  endproperty
  property p_reset_hold;
    disp.msg == kpe_pkg::KPE_M_RESET |-> !output_enable;
  endproperty
  property p_mode_freq;
    reference_mode_jumper [*4] |-> freq_mode;
  endproperty
  property p_mode_period;
    !reference_mode_jumper [*4] |-> !freq_mode;
  endproperty
  property p_commit_pulse;
    commit.valid |=> !commit.valid;
  endproperty
  property p_commit_param;
    commit.valid |-> commit.param != kpe_pkg::KPE_P_NONE;
  endproperty
  property p_ramp_show;
    ramping && disp.msg inside {kpe_pkg::KPE_M_BLANK, kpe_pkg::KPE_M_STOP}
      |-> ##[1:4] disp.msg == kpe_pkg::KPE_M_PRESENT;
  endproperty
  property p_present_digits;
    $stable(present_value) [*3] ##0 disp.msg == kpe_pkg::KPE_M_PRESENT
      |-> disp.digits == present_value;
  endproperty
  property p_idle_blank;
    idle_cnt_reg <= BLANK_CYCLES + 64'd8;
  endproperty
  property p_bar_entry;
    disp.bar_mask != 5'h00 |-> disp.msg == kpe_pkg::KPE_M_ENTRY;
  endproperty

  a_ready_status: assert property (p_ready_status) else $error("ready without status");
  a_reset_hold: assert property (p_reset_hold) else $error("output live in reset hold");
  a_mode_freq: assert property (p_mode_freq) else $error("frequency mode lost");
  a_mode_period: assert property (p_mode_period) else $error("period mode lost");
  a_commit_pulse: assert property (p_commit_pulse) else $error("commit held");
  a_commit_param: assert property (p_commit_param) else $error("commit to no target");
  a_ramp_show: assert property (p_ramp_show) else $error("ramp value not shown");
  a_present_digits: assert property (p_present_digits) else $error("wrong ramp digits");
  a_idle_blank: assert property (p_idle_blank) else $error("display not blanked");
  a_bar_entry: assert property (p_bar_entry) else $error("bars outside entry");

  c_ready: cover property ($rose(ready_led));
  c_reset_msg: cover property (disp.msg == kpe_pkg::KPE_M_RESET);
  c_present: cover property (disp.msg == kpe_pkg::KPE_M_PRESENT);
  c_blank: cover property (disp.msg == kpe_pkg::KPE_M_STOP ##1 disp.msg == kpe_pkg::KPE_M_BLANK);
endmodule // kpe_keypad_monitor

/* verification/kpe_operator.sv */
// Operator at the keypad plus the external run contact
module kpe_operator (
  // Clock
  input wire logic clk_sys,
  // Keypad and contact
  output logic [15:0] key_raw,
  output logic run_contact
);
  timeunit 1ns;
  timeprecision 1ps;

  // Open membrane contacts read as not pressed
  initial begin
    key_raw = 16'h0000;
    run_contact = 1'b0;
  end

  // Close or open the run contact just after an edge
  task automatic set_run(input logic closed);
    @(posedge clk_sys);
    run_contact <= closed;
  endtask

  // One press held long enough to pass the debounce
  task automatic press_key(input logic [3:0] code, input int hold);
    @(posedge clk_sys);
    key_raw[code] <= 1'b1;
    repeat (hold) @(posedge clk_sys);
    key_raw <= 16'h0000;
    repeat (hold) @(posedge clk_sys);
  endtask
endmodule // kpe_operator

/* verification/tb_keypad_parameter_entry.sv */
// Self-checking bench for the keypad front-end
module tb_keypad_parameter_entry;
  timeunit 1ns;
  timeprecision 1ps;

  localparam longint BLANK_SIM = 200; // Shortened auto-blank time

  logic clk_sys; // System clock
  logic rst_b; // Active low reset
  logic ramping; // Ramp engine status
  logic reference_mode_jumper; // Mode strap
  logic [19:0] present_value; // Ramp readout
  logic [19:0] param_value; // Stored value readout
  logic [15:0] key_raw; // Keypad contacts
  logic run_contact; // Run contact
  kpe_pkg::kpe_disp_t disp; // Display contents
  logic ready_led; // Ready indicator
  logic output_enable; // Pulse output allowed
  logic freq_mode; // Mode seen by the design
  kpe_pkg::kpe_param_t view_param; // Parameter in view
  kpe_pkg::kpe_commit_t commit; // Commit strobe
  int mismatches; // Failed compares
  int comparisons; // All compares
  int cycle_cnt; // Watchdog count
  kpe_pkg::kpe_commit_t commit_seen; // Last commit
  int commit_cnt = 0; // Commits seen

  // ****************************************
  // Instances
  // ****************************************
  kpe_keypad #(.BLANK_CYCLES(BLANK_SIM), .DEBOUNCE_CYCLES(4)) uut (
    .clk_sys(clk_sys), .rst_b(rst_b), .key_raw(key_raw), .run_contact(run_contact),
    .reference_mode_jumper(reference_mode_jumper), .ramping(ramping),
    .present_value(present_value), .param_value(param_value), .disp(disp),
    .ready_led(ready_led), .output_enable(output_enable), .freq_mode(freq_mode),
    .view_param(view_param), .commit(commit)
  );
  kpe_operator op (.clk_sys(clk_sys), .key_raw(key_raw), .run_contact(run_contact));

  // Clock generator
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end

  // Commit stands one cycle: keep it
  always @(posedge clk_sys) begin
    if (commit.valid === 1'b1) begin
      commit_seen <= commit;
      commit_cnt <= commit_cnt + 1;
    end
  end

  // Watchdog against a hang
  always @(posedge clk_sys) begin
    cycle_cnt <= cycle_cnt + 1;
    if (cycle_cnt == 3000) begin
      mismatches++;
      $display("mismatch at %0t: timeout", $time);
      print_verdict();
    end
  end

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk_sys);
    @(negedge clk_sys);
  endtask

  // One press past the shortened debounce, then a falling edge
  task automatic key(input logic [3:0] code);
    op.press_key(code, 12);
    @(negedge clk_sys);
  endtask

  // Reset for 10 cycles with the run contact set beforehand
  task automatic do_reset(input logic closed);
    op.set_run(closed);
    rst_b <= 1'b0;
    repeat (10) @(posedge clk_sys);
    rst_b <= 1'b1;
    wait_cyc(8);
  endtask

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic test_powerup_stop();
    do_reset(1'b0);
    check(32'(disp.msg), 32'(kpe_pkg::KPE_M_STOP));
    check(32'(ready_led), 32'h1);
    check(32'(output_enable), 32'h1);
    $display("test powerup_stop done");
  endtask

  // STOP left alone until the idle time runs out
  task automatic test_auto_blank();
    wait_cyc(int'(BLANK_SIM) + 20);
    check(32'(disp.msg), 32'(kpe_pkg::KPE_M_BLANK));
    check(32'(commit.valid), 32'h0);
    $display("test auto_blank done");
  endtask

  task automatic test_ramp_display();
    @(posedge clk_sys);
    ramping <= 1'b1;
    present_value <= 20'h06000;
    wait_cyc(6);
    check(32'(disp.msg), 32'(kpe_pkg::KPE_M_PRESENT));
    check(32'(disp.digits), 32'h06000);
    @(posedge clk_sys);
    ramping <= 1'b0;
    wait_cyc(4);
    $display("test ramp_display done");
  endtask

  task automatic test_jumper();
    @(posedge clk_sys);
    reference_mode_jumper <= 1'b0;
    wait_cyc(5);
    check(32'(freq_mode), 32'h0);
    @(posedge clk_sys);
    reference_mode_jumper <= 1'b1;
    wait_cyc(5);
    check(32'(freq_mode), 32'h1);
    $display("test jumper done");
  endtask

  // Power applied with the contact closed, then released
  task automatic test_powerup_reset();
    do_reset(1'b1);
    check(32'(disp.msg), 32'(kpe_pkg::KPE_M_RESET));
    check(32'(output_enable), 32'h0);
    op.set_run(1'b0);
    wait_cyc(8);
    check(32'(output_enable), 32'h1);
    check(32'(disp.msg == kpe_pkg::KPE_M_RESET), 32'h0);
    $display("test powerup_reset done");
  endtask

  // View, five digits with bars, commit on ENTER
  task automatic test_entry();
    key(kpe_pkg::KEY_CLEAR);
    key(kpe_pkg::KEY_MAXF);
    check(32'(disp.msg), 32'(kpe_pkg::KPE_M_PARAM));
    check(32'(view_param), 32'(kpe_pkg::KPE_P_MAXF));
    key(4'h0);
    check(32'(disp.bar_mask), 32'h0F);
    key(4'h9);
    key(4'h0);
    key(4'h0);
    key(4'h0);
    check(32'(disp.bar_mask), 32'h00);
    check(32'(commit_cnt), 32'h0);
    key(kpe_pkg::KEY_ENTER);
    check(32'(commit_cnt), 32'h1);
    check(32'(commit_seen.value), 32'h09000);
    check(32'(commit_seen.param), 32'(kpe_pkg::KPE_P_MAXF));
    check(32'(disp.msg), 32'(kpe_pkg::KPE_M_BLANK));
    $display("test entry done");
  endtask

  // Digit first, abort, status restore, short entry
  task automatic test_sequences();
    key(4'h0);
    check(32'(disp.msg), 32'(kpe_pkg::KPE_M_ERROR));
    key(kpe_pkg::KEY_CLEAR);
    check(32'(disp.msg), 32'(kpe_pkg::KPE_M_BLANK));
    key(kpe_pkg::KEY_PFREQ);
    check(32'(disp.msg), 32'(kpe_pkg::KPE_M_STOP));
    key(kpe_pkg::KEY_CLEAR);
    key(kpe_pkg::KEY_ACCEL);
    key(4'h5);
    key(kpe_pkg::KEY_ENTER);
    check(32'(disp.msg), 32'(kpe_pkg::KPE_M_ERROR));
    check(32'(commit_cnt), 32'h1);
    $display("test sequences done");
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    rst_b = 1'b0;
    ramping = 1'b0;
    reference_mode_jumper = 1'b1;
    present_value = 20'h00000;
    param_value = 20'h00000;
    mismatches = 0;
    comparisons = 0;
    cycle_cnt = 0;
    test_powerup_stop();
    test_auto_blank();
    test_ramp_display();
    test_jumper();
    test_powerup_reset();
    test_entry();
    test_sequences();
    print_verdict();
  end
endmodule // tb_keypad_parameter_entry

bind kpe_keypad kpe_keypad_monitor #(.BLANK_CYCLES(BLANK_CYCLES)) u_monitor (
  .clk_sys(clk_sys), .rst_b(rst_b), .key_raw(key_raw),
  .reference_mode_jumper(reference_mode_jumper), .ramping(ramping),
  .present_value(present_value), .disp(disp), .ready_led(ready_led),
  .output_enable(output_enable), .freq_mode(freq_mode), .commit(commit)
);
